// [include/psc_consts.svh]
/*
 protocol selection config: register offsets, field masks, reset values and
 selection codes. assumes inclusion by bare name from design files.
*/
`ifndef PSC_CONSTS_SVH
`define PSC_CONSTS_SVH

// ===========================================================
// register offsets
`define PSC_OFF_SEL 8'h16
`define PSC_OFF_ADDR 8'h18
`define PSC_OFF_SRC0 8'h1A
`define PSC_OFF_SRC1 8'h1B

// ===========================================================
// writable bit masks, reserved bits read zero
`define PSC_MASK_SEL 8'h07
`define PSC_MASK_ADDR 8'h0F
`define PSC_MASK_SRC0 8'hFF
`define PSC_MASK_SRC1 8'h8F

// ===========================================================
// reset values (unprogrammed fuse pattern)
`define PSC_RST_REG 8'h00

// ===========================================================
// selection codes
`define PSC_SEL_DSI3_SPI 3'h0
`define PSC_SEL_PSI5_SPI 3'h1
`define PSC_SEL_SPI_A 3'h2
`define PSC_SEL_DSI3 3'h3
`define PSC_SEL_SPI_B 3'h4
`define PSC_SEL_PSI5 3'h5
`define PSC_SEL_I2C_A 3'h6
`define PSC_SEL_I2C_B 3'h7

`endif

// [include/psc_pkg.sv]
/*
 types shared by the protocol selection config block and its users.
 assumes compilation before every design file.
*/
package psc_pkg;

   // ===========================================================
   // request kinds and carriers
   typedef enum logic [1:0] {PSC_RD, PSC_WR, PSC_DATA, PSC_TEST} psc_kind_t;

   typedef struct packed {
      psc_kind_t kind;
      logic [7:0] addr;
      logic [7:0] wdata;
   } psc_req_t;

   typedef struct packed {
      logic [7:0] rdata;
      logic err;
   } psc_rsp_t;

   typedef struct packed {
      logic dsi3;
      logic psi5;
      logic spi;
      logic i2c;
   } psc_proto_t;

   typedef struct packed {
      logic en;
      logic [2:0] fmt;
      logic [3:0] tag;
   } psc_src_t;

   typedef enum logic {PSC_LOAD, PSC_RUN} psc_state_t;

endpackage

// [src/psc_arb.sv]
/*
 two-channel arbiter granting one register access a cycle in arrival order.
 assumes requests hold valid and data until ready.
*/
`timescale 1ns/10ps

module psc_arb (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // control
   input wire logic en_in,
   input wire logic [1:0] valid_in,
   // grants
   output logic [1:0] ready_out
);

   logic wait1_ff;
   logic pick1;

   // a channel left waiting wins a tie; fresh ties go to channel 0
   assign pick1 = valid_in[1] & (~valid_in[0] | wait1_ff);
   assign ready_out[1] = en_in & pick1;
   assign ready_out[0] = en_in & valid_in[0] & ~pick1;

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         wait1_ff <= 1'b0;
      end else begin
         wait1_ff <= valid_in[1] & ~ready_out[1];
      end
   end

   property p_order;
      @(posedge clk_in) disable iff (!rst_b_in)
      (en_in && valid_in[1] && !ready_out[1]) |=> !en_in || !valid_in[1] || ready_out[1];
   endproperty
   a_order: assert property (p_order) else $error("waiting channel lost its turn");

endmodule

// [src/psc_parity_guard.sv]
/*
 array error detection: a parity bit per register, taken on every write or
 load, compared against the register content each cycle it is not written.
 assumes we_in and wdata_in carry the value the register takes next edge.
*/
`timescale 1ns/10ps

module psc_parity_guard #(
   parameter int N = 4
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // register traffic
   input wire logic [N-1:0] we_in,
   input wire logic [N-1:0][7:0] wdata_in,
   input wire logic [N-1:0][7:0] regs_in,
   // status
   output logic err_out
);

   logic [N-1:0] par_ff;
   logic [N-1:0] bad;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_par
         always_ff @(posedge clk_in) begin
            if (!rst_b_in) begin
               par_ff[g] <= 1'b0;
            end else if (we_in[g]) begin
               par_ff[g] <= ^wdata_in[g];
            end
         end
         assign bad[g] = ~we_in[g] & (par_ff[g] != ^regs_in[g]);
      end
   endgenerate

   // sticky: an upset is kept until reset so software cannot miss it
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         err_out <= 1'b0;
      end else if (|bad) begin
         err_out <= 1'b1;
      end
   end

endmodule

// [src/psc_top.sv]
/*
 protocol selection config register group: protocol choice, arming and
 undervoltage gating, node address and two data source descriptors.
 assumes fuse values and status inputs come from logic on clk_in, and that
 protocol engines present register accesses on two request channels.
*/
`timescale 1ns/10ps
`include "psc_consts.svh"

// Behaviour
// - selection register readable and writable in DSI3, SPI and I2C
// - changing selection in PSI5 programming mode flags user fuse error
// - selection low three bits pick protocols, upper bits reserved
// - arming follows its config for codes 0,1,2,4, else off
// - bus undervoltage for codes 3,5 only, else buffer supply monitored
// - selection that disables an active protocol waits for reset
// - running codes 2 to 7 never change protocol on write
// - code 1 ignores SPI until PSI5 init phase 3, test entry allowed
// - code 1 accepts only SPI register reads and test entry, rejects writes and data
// - codes 0 and 1 complete accesses in arrival order
// - selection, address and source registers under array error check
// - node address four bits, upper zero, zero means discovery assigns
// - non-zero fused address skips discovery and is used directly
// - register write may change address, reset reloads fused value
// - node address has no effect outside DSI3
// - source registers RW in DSI3, SPI, I2C, PSI5 programming
// - source fields: enable bit7, format 6:4, tag 3:0, reserved 6:4 in source 1
// - source enable switches its data source on or off
module psc_top (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // fused values and device status
   input wire logic [7:0] fuse_sel_in,
   input wire logic [7:0] fuse_addr_in,
   input wire logic [7:0] fuse_src0_in,
   input wire logic [7:0] fuse_src1_in,
   input wire logic psi5_prog_in,
   input wire logic psi5_init3_done_in,
   input wire logic [2:0] arm_cfg_in,
   // main protocol request channel (DSI3, PSI5 or I2C engine)
   input wire logic bus_req_valid_in,
   input wire psc_pkg::psc_req_t bus_req_in,
   output logic bus_req_ready_out,
   // SPI request channel
   input wire logic spi_req_valid_in,
   input wire psc_pkg::psc_req_t spi_req_in,
   output logic spi_req_ready_out,
   // answers
   output logic rsp_valid_out,
   output logic rsp_chan_out,
   output psc_pkg::psc_rsp_t rsp_out,
   // configuration to the device
   output psc_pkg::psc_proto_t proto_en_out,
   output logic arming_en_out,
   output logic bus_uv_en_out,
   output logic buf_uv_en_out,
   output logic discovery_en_out,
   output logic [3:0] node_addr_out,
   output psc_pkg::psc_src_t src0_out,
   output psc_pkg::psc_src_t src1_out,
   // events and errors
   output logic spi_test_entry_out,
   output logic user_fuse_err_out,
   output logic array_err_out
);
   import psc_pkg::*;

   localparam int NREG = 4;
   localparam logic [NREG-1:0][7:0] OFFS =
      {`PSC_OFF_SRC1, `PSC_OFF_SRC0, `PSC_OFF_ADDR, `PSC_OFF_SEL};
   localparam logic [NREG-1:0][7:0] MASKS =
      {`PSC_MASK_SRC1, `PSC_MASK_SRC0, `PSC_MASK_ADDR, `PSC_MASK_SEL};
   localparam int I_SEL = 0;
   localparam int I_ADDR = 1;
   localparam int I_SRC0 = 2;
   localparam int I_SRC1 = 3;

   // ===========================================================
   // selection decode
   function automatic psc_proto_t proto_of(input logic [2:0] code);
      psc_proto_t p;
      p = '0;
      unique case (code)
         `PSC_SEL_DSI3_SPI: begin
            p.dsi3 = 1'b1;
            p.spi = 1'b1;
         end
         `PSC_SEL_PSI5_SPI: begin
            p.psi5 = 1'b1;
            p.spi = 1'b1;
         end
         `PSC_SEL_SPI_A, `PSC_SEL_SPI_B: p.spi = 1'b1;
         `PSC_SEL_DSI3: p.dsi3 = 1'b1;
         `PSC_SEL_PSI5: p.psi5 = 1'b1;
         `PSC_SEL_I2C_A, `PSC_SEL_I2C_B: p.i2c = 1'b1;
      endcase
      return p;
   endfunction

   // ===========================================================
   // state
   psc_state_t state_ff;
   logic [2:0] active_sel_ff;
   logic [NREG-1:0][7:0] regs_ff;
   logic fuse_addr_zero_ff;
   logic rsp_valid_ff;
   logic rsp_chan_ff;
   psc_rsp_t rsp_ff;
   logic spi_test_ff;
   logic user_fuse_err_ff;

   logic loading;
   logic [1:0] ready;
   logic gnt;
   logic gnt_chan;
   psc_req_t gnt_req;
   logic [NREG-1:0] hit;
   logic [NREG-1:0] we;
   logic [NREG-1:0][7:0] new_val;
   logic [NREG-1:0][7:0] fuse_val;
   logic spi_drop;
   logic spi_rej;
   logic psi5_lock;
   logic wr;
   logic sel_wr;
   logic [2:0] new_sel;
   psc_proto_t act_p;
   psc_proto_t new_p;
   logic [7:0] rdata;

   assign loading = state_ff == PSC_LOAD;
   assign act_p = proto_of(active_sel_ff);
   assign fuse_val = {fuse_src1_in, fuse_src0_in, fuse_addr_in, fuse_sel_in};

   // ===========================================================
   // request ordering
   psc_arb u_arb (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .en_in(~loading),
      .valid_in({spi_req_valid_in, bus_req_valid_in}),
      .ready_out(ready)
   );

   assign bus_req_ready_out = ready[0];
   assign spi_req_ready_out = ready[1];
   assign gnt = |ready;
   assign gnt_chan = ready[1];
   assign gnt_req = ready[1] ? spi_req_in : bus_req_in;

   // ===========================================================
   // access checks
   always_comb begin
      spi_drop = 1'b0;
      spi_rej = 1'b0;
      if (gnt_chan && active_sel_ff == `PSC_SEL_PSI5_SPI) begin
         spi_drop = ~psi5_init3_done_in && gnt_req.kind != PSC_TEST;
         spi_rej = gnt_req.kind == PSC_WR || gnt_req.kind == PSC_DATA;
      end
   end

   // over PSI5 only programming mode may touch the registers
   assign psi5_lock = ~gnt_chan & act_p.psi5 & ~psi5_prog_in;
   assign wr = gnt & gnt_req.kind == PSC_WR & ~spi_drop & ~spi_rej & ~psi5_lock;

   always_comb begin
      for (int i = 0; i < NREG; i++) begin
         hit[i] = gnt_req.addr == OFFS[i];
         new_val[i] = (loading ? fuse_val[i] : gnt_req.wdata) & MASKS[i];
         we[i] = loading | (wr & hit[i]);
      end
   end

   // ===========================================================
   // control state
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         state_ff <= PSC_LOAD;
      end else begin
         state_ff <= PSC_RUN;
      end
   end

   // ===========================================================
   // register array, loaded from fuses once after each reset
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         regs_ff <= {NREG{`PSC_RST_REG}};
      end else begin
         for (int i = 0; i < NREG; i++) begin
            if (we[i]) begin
               regs_ff[i] <= new_val[i];
            end
         end
      end
   end

   // ===========================================================
   // running protocol: a change that drops an active protocol waits
   assign sel_wr = wr & hit[I_SEL];
   assign new_sel = new_val[I_SEL][2:0];
   assign new_p = proto_of(new_sel);

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         active_sel_ff <= 3'h0;
      end else if (loading) begin
         active_sel_ff <= fuse_sel_in[2:0];
      end else if (sel_wr && !active_sel_ff[2] && !active_sel_ff[1]
                   && (new_p & act_p) == act_p) begin
         // codes 2..7 never switch at run time; 0 and 1 only widen
         active_sel_ff <= new_sel;
      end
   end

   // ===========================================================
   // fused address capture for discovery decision
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         fuse_addr_zero_ff <= 1'b1;
      end else if (loading) begin
         fuse_addr_zero_ff <= (fuse_addr_in & `PSC_MASK_ADDR) == 8'h00;
      end
   end

   // ===========================================================
   // user fuse error: sticky until reset
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         user_fuse_err_ff <= 1'b0;
      end else if (sel_wr && psi5_prog_in && new_val[I_SEL] != regs_ff[I_SEL]) begin
         user_fuse_err_ff <= 1'b1;
      end
   end

   // ===========================================================
   // answers
   always_comb begin
      rdata = 8'h00;
      for (int i = 0; i < NREG; i++) begin
         if (hit[i]) begin
            rdata = rdata | regs_ff[i];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         rsp_valid_ff <= 1'b0;
         rsp_chan_ff <= 1'b0;
         rsp_ff <= '0;
      end else begin
         rsp_valid_ff <= gnt & ~spi_drop;
         rsp_chan_ff <= gnt_chan;
         rsp_ff.err <= spi_rej | psi5_lock
                       | ((gnt_req.kind == PSC_RD || gnt_req.kind == PSC_WR) & ~|hit);
         rsp_ff.rdata <= (gnt_req.kind == PSC_RD && !spi_rej) ? rdata : 8'h00;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         spi_test_ff <= 1'b0;
      end else begin
         spi_test_ff <= gnt & gnt_chan & gnt_req.kind == PSC_TEST;
      end
   end

   // ===========================================================
   // array error detection
   psc_parity_guard #(
      .N(NREG)
   ) u_guard (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .we_in(we),
      .wdata_in(new_val),
      .regs_in(regs_ff),
      .err_out(array_err_out)
   );

   // ===========================================================
   // outputs
   assign rsp_valid_out = rsp_valid_ff;
   assign rsp_chan_out = rsp_chan_ff;
   assign rsp_out = rsp_ff;
   assign spi_test_entry_out = spi_test_ff;
   assign user_fuse_err_out = user_fuse_err_ff;
   assign proto_en_out = act_p;
   // arming only where SPI is among the protocols: codes 0,1,2,4
   assign arming_en_out = act_p.spi & (arm_cfg_in != 3'h0);
   assign bus_uv_en_out = (act_p.dsi3 | act_p.psi5) & ~act_p.spi;
   assign buf_uv_en_out = ~bus_uv_en_out;
   // address is meaningless outside DSI3, so it is held at zero there
   assign discovery_en_out = act_p.dsi3 & fuse_addr_zero_ff;
   assign node_addr_out = act_p.dsi3 ? regs_ff[I_ADDR][3:0] : 4'h0;
   assign src0_out = regs_ff[I_SRC0];
   assign src1_out = regs_ff[I_SRC1];

   // ===========================================================
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);

   property p_proto;
      proto_en_out.spi == (active_sel_ff inside {`PSC_SEL_DSI3_SPI, `PSC_SEL_PSI5_SPI,
                                                 `PSC_SEL_SPI_A, `PSC_SEL_SPI_B});
   endproperty
   a_proto: assert property (p_proto) else $error("spi enable disagrees with code");

   property p_arm;
      arming_en_out |-> arm_cfg_in != 3'h0 && active_sel_ff != `PSC_SEL_DSI3
         && active_sel_ff != `PSC_SEL_PSI5 && !active_sel_ff[2] | !active_sel_ff[1];
   endproperty
   a_arm: assert property (p_arm) else $error("arming enabled for wrong code");

   property p_uv;
      (bus_uv_en_out != buf_uv_en_out)
      && (bus_uv_en_out == (active_sel_ff inside {`PSC_SEL_DSI3, `PSC_SEL_PSI5}));
   endproperty
   a_uv: assert property (p_uv) else $error("undervoltage monitor choice wrong");

   property p_hold;
      (!loading && active_sel_ff inside {[`PSC_SEL_SPI_A:`PSC_SEL_I2C_B]})
      |=> $stable(active_sel_ff);
   endproperty
   a_hold: assert property (p_hold) else $error("protocol changed at run time");

   property p_defer;
      (sel_wr && (new_p & act_p) != act_p) |=> $stable(active_sel_ff)[*2];
   endproperty
   a_defer: assert property (p_defer) else $error("disabling change not deferred");

   property p_ignore;
      (gnt && gnt_chan && active_sel_ff == `PSC_SEL_PSI5_SPI && !psi5_init3_done_in
       && gnt_req.kind != PSC_TEST) |=> !rsp_valid_out;
   endproperty
   a_ignore: assert property (p_ignore) else $error("spi answered before init 3");

   property p_reject;
      (gnt && gnt_chan && active_sel_ff == `PSC_SEL_PSI5_SPI && psi5_init3_done_in
       && gnt_req.kind == PSC_WR) |=> rsp_valid_out && rsp_out.err && $stable(regs_ff);
   endproperty
   a_reject: assert property (p_reject) else $error("spi write not rejected");

   property p_fuse_err;
      (sel_wr && psi5_prog_in && new_val[I_SEL] != regs_ff[I_SEL]) |=> user_fuse_err_out;
   endproperty
   a_fuse_err: assert property (p_fuse_err) else $error("fuse error not raised");

   property p_addr_rb;
      (gnt && gnt_req.kind == PSC_RD && hit[I_ADDR] && !spi_rej)
      |=> rsp_out.rdata[7:4] == 4'h0;
   endproperty
   a_addr_rb: assert property (p_addr_rb) else $error("address upper bits not zero");

   property p_no_dsi3;
      !proto_en_out.dsi3 |-> node_addr_out == 4'h0 && !discovery_en_out;
   endproperty
   a_no_dsi3: assert property (p_no_dsi3) else $error("address used outside dsi3");

endmodule

// [test/psc_host_model.sv]
/*
 host model for one register request channel of psc_top, acting as bus master.
 assumes the bench calls access and nothing else drives this channel.
*/
`timescale 1ns/10ps

module psc_host_model #(
   parameter logic CHAN = 1'b0
) (
   // clock and answers
   input wire logic clk_in,
   input wire logic ready_in,
   input wire logic rsp_valid_in,
   input wire logic rsp_chan_in,
   // request
   output logic valid_out,
   output psc_pkg::psc_req_t req_out
);
   import psc_pkg::*;
   time ans_time;
   initial begin
      valid_out = 1'b0;
      req_out = '0;
      ans_time = 0;
   end
   // ===========================================================
   // request held from a falling edge up to the falling edge after the rising edge that sees ready
   task automatic access(input psc_kind_t k, input logic [7:0] a, input logic [7:0] d,
                         output bit taken, output bit got);
      taken = 1'b0;
      @(negedge clk_in);
      valid_out = 1'b1;
      // any request kind: register accesses, data and test entry alike
      req_out = '{k, a, d};
      for (int n = 0; n < 40 && !taken; n++) begin
         @(posedge clk_in);
         taken = (ready_in === 1'b1);
      end
      @(negedge clk_in);
      got = (rsp_valid_in === 1'b1) && (rsp_chan_in === CHAN);
      if (got) begin
         ans_time = $time;
      end
      valid_out = 1'b0;
      // released lines carry the inverse so a stale request never looks live
      req_out = psc_req_t'(~req_out);
   endtask
endmodule

// [test/psc_top_tb_top.sv]
/*
 testbench for psc_top: host models on the main and spi channels.
 assumes psc_pkg and the constants header are compiled first.
*/
`timescale 1ns/10ps
`include "psc_consts.svh"

module psc_top_tb_top;
   import psc_pkg::*;
   // ===========================================================
   // signals
   logic clk_in, rst_b_in, psi5_prog_in, psi5_init3_done_in;
   logic [7:0] fuse_sel_in, fuse_addr_in, fuse_src0_in, fuse_src1_in;
   logic [2:0] arm_cfg_in;
   logic bus_req_valid_in, bus_req_ready_out, spi_req_valid_in, spi_req_ready_out;
   psc_req_t bus_req_in, spi_req_in;
   logic rsp_valid_out, rsp_chan_out, arming_en_out, bus_uv_en_out, buf_uv_en_out;
   logic discovery_en_out, spi_test_entry_out, user_fuse_err_out, array_err_out;
   logic [3:0] node_addr_out;
   psc_rsp_t rsp_out;
   psc_proto_t proto_en_out, e;
   psc_src_t src0_out, src1_out;
   int fail_count = 0, num_checks = 0, pulses = 0, p;
   bit t1, t2, g1, g2, sp;

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   // counted mid-cycle, where the one-cycle pulse has settled
   always @(negedge clk_in) begin
      if (spi_test_entry_out === 1'b1) begin
         pulses++;
      end
   end

   psc_top i_psc_top (.clk_in(clk_in), .rst_b_in(rst_b_in), .fuse_sel_in(fuse_sel_in),
      .fuse_addr_in(fuse_addr_in), .fuse_src0_in(fuse_src0_in), .fuse_src1_in(fuse_src1_in),
      .psi5_prog_in(psi5_prog_in), .psi5_init3_done_in(psi5_init3_done_in),
      .arm_cfg_in(arm_cfg_in), .bus_req_valid_in(bus_req_valid_in), .bus_req_in(bus_req_in),
      .bus_req_ready_out(bus_req_ready_out), .spi_req_valid_in(spi_req_valid_in),
      .spi_req_in(spi_req_in), .spi_req_ready_out(spi_req_ready_out),
      .rsp_valid_out(rsp_valid_out), .rsp_chan_out(rsp_chan_out), .rsp_out(rsp_out),
      .proto_en_out(proto_en_out), .arming_en_out(arming_en_out),
      .bus_uv_en_out(bus_uv_en_out), .buf_uv_en_out(buf_uv_en_out),
      .discovery_en_out(discovery_en_out), .node_addr_out(node_addr_out),
      .src0_out(src0_out), .src1_out(src1_out), .spi_test_entry_out(spi_test_entry_out),
      .user_fuse_err_out(user_fuse_err_out), .array_err_out(array_err_out));
   psc_host_model #(.CHAN(1'b0)) i_psc_host_model_bus (.clk_in(clk_in),
      .ready_in(bus_req_ready_out), .rsp_valid_in(rsp_valid_out), .rsp_chan_in(rsp_chan_out),
      .valid_out(bus_req_valid_in), .req_out(bus_req_in));
   psc_host_model #(.CHAN(1'b1)) i_psc_host_model_spi (.clk_in(clk_in),
      .ready_in(spi_req_ready_out), .rsp_valid_in(rsp_valid_out), .rsp_chan_in(rsp_chan_out),
      .valid_out(spi_req_valid_in), .req_out(spi_req_in));

   // ===========================================================
   // shared tasks
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] s);
      num_checks++;
      if (s !== ex) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, ex, s);
      end
   endtask
   task automatic xfer(input bit s, input psc_kind_t k, input logic [7:0] a,
                       input logic [7:0] d, input logic ans, input logic er);
      bit tk, g;
      if (s) begin
         i_psc_host_model_spi.access(k, a, d, tk, g);
      end else begin
         i_psc_host_model_bus.access(k, a, d, tk, g);
      end
      if (!tk) begin
         fail_count++;
         $display("FAIL request_taken expected 1 seen 0");
         conclude();
      end
      chk("answered", {7'h00, ans}, {7'h00, g});
      if (g) begin
         chk("rsp_err", {7'h00, er}, {7'h00, rsp_out.err});
      end
   endtask
   task automatic rd(input bit s, input logic [7:0] a, input logic [7:0] ex);
      xfer(s, PSC_RD, a, 8'h00, 1'b1, 1'b0);
      chk("rdata", ex, rsp_out.rdata);
   endtask
   task automatic do_reset(input logic [7:0] sel);
      @(negedge clk_in);
      rst_b_in = 1'b0;
      fuse_sel_in = sel;
      repeat (16) @(negedge clk_in);
      rst_b_in = 1'b1;
      repeat (2) @(negedge clk_in);
   endtask
   function automatic psc_proto_t exp_proto(input logic [2:0] c);
      case (c)
         `PSC_SEL_DSI3_SPI: exp_proto = 4'b1010;
         `PSC_SEL_PSI5_SPI: exp_proto = 4'b0110;
         `PSC_SEL_DSI3: exp_proto = 4'b1000;
         `PSC_SEL_PSI5: exp_proto = 4'b0100;
         `PSC_SEL_I2C_A, `PSC_SEL_I2C_B: exp_proto = 4'b0001;
         default: exp_proto = 4'b0010;
      endcase
   endfunction

   // ===========================================================
   // scenarios
   initial begin
      rst_b_in = 1'b0;
      psi5_prog_in = 1'b0;
      psi5_init3_done_in = 1'b0;
      arm_cfg_in = 3'h2;
      fuse_addr_in = 8'hF5;
      fuse_src0_in = 8'hA3;
      fuse_src1_in = 8'hFF;
      fuse_sel_in = 8'h00;
      // fused values after reset, reserved bits cleared
      do_reset(8'h00);
      rd(1'b0, `PSC_OFF_ADDR, 8'h05);
      rd(1'b0, `PSC_OFF_SRC0, 8'hA3);
      rd(1'b1, `PSC_OFF_SRC1, 8'h8F);
      chk("discovery_en", 8'h00, {7'h00, discovery_en_out});
      chk("node_addr", 8'h05, {4'h0, node_addr_out});
      $display("test fused_reset done");
      // writes through both channels
      xfer(1'b0, PSC_WR, `PSC_OFF_ADDR, 8'hFA, 1'b1, 1'b0);
      rd(1'b1, `PSC_OFF_ADDR, 8'h0A);
      chk("node_addr", 8'h0A, {4'h0, node_addr_out});
      xfer(1'b1, PSC_WR, `PSC_OFF_SRC1, 8'h7F, 1'b1, 1'b0);
      rd(1'b0, `PSC_OFF_SRC1, 8'h0F);
      chk("src1", 8'h0F, src1_out);
      xfer(1'b0, PSC_WR, `PSC_OFF_SRC0, 8'hDC, 1'b1, 1'b0);
      chk("src0", 8'hDC, src0_out);
      xfer(1'b1, PSC_WR, `PSC_OFF_SEL, 8'hF9, 1'b1, 1'b0);
      rd(1'b0, `PSC_OFF_SEL, 8'h01);
      chk("proto_en", 8'h0A, {4'h0, proto_en_out});
      xfer(1'b0, PSC_RD, 8'h17, 8'h00, 1'b1, 1'b1);
      chk("array_err", 8'h00, {7'h00, array_err_out});
      $display("test reg_access done");
      // simultaneous requests, main channel wins the tie
      fork
         i_psc_host_model_bus.access(PSC_RD, `PSC_OFF_SEL, 8'h00, t1, g1);
         i_psc_host_model_spi.access(PSC_RD, `PSC_OFF_ADDR, 8'h00, t2, g2);
      join
      chk("both_answered", 8'h03, {6'h00, g1 & t1, g2 & t2});
      chk("main_first", 8'h01,
          {7'h00, i_psc_host_model_bus.ans_time < i_psc_host_model_spi.ans_time});
      chk("last_rdata", 8'h0A, rsp_out.rdata);
      $display("test arrival_order done");
      for (int a = 0; a < 8; a++) begin
         @(negedge clk_in);
         arm_cfg_in = a[2:0];
         #1;
         chk("arming_en", {7'h00, a != 0}, {7'h00, arming_en_out});
      end
      $display("test arming done");
      // every selection code from the fuses, then for all but codes 1 and 5 a write that must not switch
      arm_cfg_in = 3'h2;
      fuse_addr_in = 8'h00;
      for (int c = 0; c < 8; c++) begin
         do_reset({5'h00, c[2:0]});
         e = exp_proto(c[2:0]);
         chk("proto_en", {4'h0, e}, {4'h0, proto_en_out});
         chk("bus_uv_en", {7'h00, c == 3 || c == 5}, {7'h00, bus_uv_en_out});
         chk("buf_uv_en", {7'h00, c != 3 && c != 5}, {7'h00, buf_uv_en_out});
         chk("arming_en", {7'h00, e.spi}, {7'h00, arming_en_out});
         chk("discovery_en", {7'h00, e.dsi3}, {7'h00, discovery_en_out});
         if (c != 1 && c != 5) begin
            sp = !e.dsi3 && !e.i2c;
            xfer(sp, PSC_WR, `PSC_OFF_ADDR, 8'h09, 1'b1, 1'b0);
            chk("node_addr", {4'h0, e.dsi3 ? 4'h9 : 4'h0}, {4'h0, node_addr_out});
            xfer(sp, PSC_WR, `PSC_OFF_SEL, {5'h00, ~c[2:0]}, 1'b1, 1'b0);
            chk("proto_en", {4'h0, e}, {4'h0, proto_en_out});
         end
      end
      $display("test selection_codes done");
      // psi5 plus spi: spi held off until init phase 3 save test entry, then reads only
      do_reset(8'h01);
      xfer(1'b1, PSC_RD, `PSC_OFF_SEL, 8'h00, 1'b0, 1'b0);
      p = pulses;
      xfer(1'b1, PSC_TEST, 8'h00, 8'h00, 1'b1, 1'b0);
      repeat (2) @(negedge clk_in);
      chk("test_entry", 8'h01, 8'(pulses - p));
      psi5_init3_done_in = 1'b1;
      rd(1'b1, `PSC_OFF_SEL, 8'h01);
      xfer(1'b1, PSC_WR, `PSC_OFF_SRC0, 8'h11, 1'b1, 1'b1);
      xfer(1'b1, PSC_DATA, 8'h00, 8'h00, 1'b1, 1'b1);
      xfer(1'b0, PSC_WR, `PSC_OFF_SRC0, 8'h11, 1'b1, 1'b1);
      rd(1'b1, `PSC_OFF_SRC0, 8'hA3);
      $display("test psi5_spi done");
      // programming mode: source writes allowed, selection change flagged
      psi5_prog_in = 1'b1;
      do_reset(8'h05);
      xfer(1'b0, PSC_WR, `PSC_OFF_SRC0, 8'h3C, 1'b1, 1'b0);
      rd(1'b0, `PSC_OFF_SRC0, 8'h3C);
      xfer(1'b0, PSC_WR, `PSC_OFF_SEL, 8'h05, 1'b1, 1'b0);
      chk("user_fuse_err", 8'h00, {7'h00, user_fuse_err_out});
      xfer(1'b0, PSC_WR, `PSC_OFF_SEL, 8'h00, 1'b1, 1'b0);
      @(negedge clk_in);
      chk("user_fuse_err", 8'h01, {7'h00, user_fuse_err_out});
      chk("proto_en", 8'h04, {4'h0, proto_en_out});
      chk("array_err", 8'h00, {7'h00, array_err_out});
      $display("test psi5_prog done");
      conclude();
   end
endmodule
